// >>> usa_pkg.sv
/*
  Package for the serial unit: register map, field positions, reset values,
  timing figures and the carrier structs shared by the design.
  Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
*/
package usa_pkg;
  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_HOLDING_BUFFER = 8'h00;
  localparam logic [7:0] ADDR_TX_HOLDING_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_PRESCALE_REG = 8'h08;
  localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h0c;
  localparam logic [7:0] ADDR_FRAME_SELECT = 8'h10;
  localparam logic [7:0] ADDR_MODE_SELECT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int PSR_PRESCALE_LSB = 3;
  localparam int FRS_CHAR_LENGTH_LSB = 0;
  localparam int FRS_TWO_STOP = 2;
  localparam int FRS_TX_NINTH = 3;
  localparam int FRS_PARITY_ENABLE = 6;
  localparam int MDS_SYNC_MODE = 0;
  localparam int MDS_EXT_CLOCK = 1;
  localparam int MDS_ADDRESS_WAIT = 2;
  localparam int STA_RX_FULL = 0;
  localparam int STA_TX_EMPTY = 1;
  localparam int STA_TX_IN_PROGRESS = 2;
  localparam int STA_RX_NINTH = 3;
  // ------------------------------------------------------------------
  // Encodings, reset values and timing
  // ------------------------------------------------------------------
  localparam logic [1:0] CHAR_EIGHT = 2'h0;
  localparam logic [1:0] CHAR_SEVEN = 2'h1;
  localparam logic [1:0] CHAR_NINE = 2'h2;
  localparam logic [1:0] CHAR_LOOPBACK = 2'h3;
  localparam logic [4:0] PRESCALE_STOPPED = 5'h00;
  localparam logic [7:0] RESET_PSR = 8'h00;
  localparam logic [7:0] RESET_BAUD = 8'h00;
  localparam logic [7:0] RESET_FRS = 8'h00;
  localparam logic [2:0] RESET_MDS = 3'h0;
  localparam logic [3:0] ASYNC_OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] ASYNC_MID_BIT = 4'h7;
  localparam int FRAME_MAX = 13;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } usa_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } usa_ahb_rsp_t;
endpackage

// >>> usa_serial_unit.sv
/*
  Serial receiver/transmitter with synchronous and asynchronous framing,
  address-wait (attention) reception, internal loopback and a two-stage
  baud generator, reached over AHB-Lite.
  Assumes one system clock mclk; the serial and bit clock pins are asynchronous.
*/
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module usa_serial_unit
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire usa_pkg::usa_ahb_req_t ahbReq,
  output usa_pkg::usa_ahb_rsp_t ahbRsp,
  input wire logic serialInPin,
  output logic serialOutPin,
  input wire logic bitClockPinIn,
  output logic bitClockPinOut,
  output logic bitClockPinOe
);
  typedef struct packed {
    logic [7:0] prescaleReg;
    logic [7:0] baudDivisor;
    logic [7:0] frameSel;
    logic [2:0] modeSel;
    logic [7:0] txHoldingBuffer;
    logic txBufferEmptyFlag;
    logic [7:0] rxHoldingBuffer;
    logic rxBufferFullFlag;
    logic rxNinthBit;
    logic [5:0] preAcc;
    logic [10:0] divCnt;
    logic clkLvl;
    logic [3:0] txPhase;
    logic [12:0] txShifter;
    logic [3:0] txLeft;
    logic [3:0] rxPhase;
    logic rxActive;
    logic [3:0] rxCnt;
    logic [12:0] rxShifter;
    logic inSync1;
    logic inSync2;
    logic ckSync1;
    logic ckSync2;
    logic ckSync3;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdData;
  } usa_state_t;

  usa_state_t q;
  usa_state_t next_q;
  logic [4:0] prescale;
  logic [10:0] divisor;
  logic [1:0] charLen;
  logic syncMode;
  logic extClock;
  logic unitOn;
  logic preTick;
  logic divTick;
  logic riseEv;
  logic fallEv;
  logic txEv;
  logic rxIn;
  logic [3:0] nBits;
  logic parityOn;
  logic [3:0] frameLen;
  logic rxDone;
  logic rxAccept;
  logic [8:0] rxWord;
  logic addrPhase;
  logic rdRxBuf;
  logic txInProgress;

  // ------------------------------------------------------------------
  // Frame assembly
  // ------------------------------------------------------------------
  function automatic logic [12:0] build_frame(input logic [8:0] data, input logic [3:0] n,
                                              input logic par);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      if (i < int'(n))
      begin
        f[i + 1] = data[i];
      end
    end
    if (par)
    begin
      f[n + 4'h1] = (n == 4'h7) ? ^data[6:0] : ^data[7:0];
    end
    return f;
  endfunction

  assign prescale = q.prescaleReg[7:usa_pkg::PSR_PRESCALE_LSB];
  assign divisor = {q.prescaleReg[2:0], q.baudDivisor};
  assign charLen = q.frameSel[usa_pkg::FRS_CHAR_LENGTH_LSB +: 2];
  assign syncMode = q.modeSel[usa_pkg::MDS_SYNC_MODE];
  assign extClock = q.modeSel[usa_pkg::MDS_EXT_CLOCK];
  assign unitOn = (prescale != usa_pkg::PRESCALE_STOPPED);
  // Nine data bits for both nine-bit codes, which also forbids parity
  assign nBits = (charLen == usa_pkg::CHAR_EIGHT) ? 4'h8 :
                 (charLen == usa_pkg::CHAR_SEVEN) ? 4'h7 : 4'h9;
  assign parityOn = q.frameSel[usa_pkg::FRS_PARITY_ENABLE] && !charLen[1];
  assign frameLen = 4'h1 + nBits + {3'h0, parityOn}
                  + (q.frameSel[usa_pkg::FRS_TWO_STOP] ? 4'h2 : 4'h1);

  // ------------------------------------------------------------------
  // Baud generator and bit clock
  // ------------------------------------------------------------------
  // Half-step prescale: add two per clock, wrap at k+1
  assign preTick = unitOn && ({1'b0, q.preAcc} + 7'h02 >= {2'h0, prescale} + 7'h01);
  assign divTick = preTick && (q.divCnt == divisor);
  // External edges come from the second and third sync stages only
  assign riseEv = unitOn && (extClock ? (q.ckSync2 && !q.ckSync3) : (divTick && !q.clkLvl));
  assign fallEv = unitOn && (extClock ? (!q.ckSync2 && q.ckSync3) : (divTick && q.clkLvl));
  assign txEv = syncMode ? riseEv
              : (divTick && q.txPhase == usa_pkg::ASYNC_OVERSAMPLE_LAST);
  // Loopback bypasses the pin so no sync delay applies
  assign rxIn = (charLen == usa_pkg::CHAR_LOOPBACK) ? q.txShifter[0] | (q.txLeft == 4'h0)
                                                   : q.inSync2;
  assign txInProgress = (q.txLeft != 4'h0) || !q.txBufferEmptyFlag;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign addrPhase = ce && ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
  assign rdRxBuf = addrPhase && !ahbReq.hwrite
                 && ahbReq.haddr[7:0] == usa_pkg::ADDR_RX_HOLDING_BUFFER;

  always_comb
  begin
    next_q = q;
    rxDone = 1'b0;
    rxAccept = 1'b0;
    rxWord = 9'h000;
    next_q.inSync1 = serialInPin;
    next_q.inSync2 = q.inSync1;
    next_q.ckSync1 = bitClockPinIn;
    next_q.ckSync2 = q.ckSync1;
    next_q.ckSync3 = q.ckSync2;
    // Baud generator
    if (preTick)
    begin
      next_q.preAcc = 6'(q.preAcc + 6'h02 - {1'b0, prescale} - 6'h01);
      next_q.divCnt = divTick ? 11'h000 : 11'(q.divCnt + 11'h001);
    end
    else if (unitOn)
    begin
      next_q.preAcc = 6'(q.preAcc + 6'h02);
    end
    else
    begin
      // Restart both stages, else a smaller new divisor waits for an 11-bit wrap
      next_q.preAcc = 6'h00;
      next_q.divCnt = 11'h000;
    end
    if (divTick && !extClock)
    begin
      next_q.clkLvl = !q.clkLvl;
    end
    if (divTick && !syncMode)
    begin
      next_q.txPhase = 4'(q.txPhase + 4'h1);
    end
    // Transmitter
    if (txEv)
    begin
      if (q.txLeft > 4'h1)
      begin
        next_q.txShifter = {1'b1, q.txShifter[12:1]};
        next_q.txLeft = 4'(q.txLeft - 4'h1);
      end
      else if (!q.txBufferEmptyFlag)
      begin
        next_q.txShifter = build_frame({q.frameSel[usa_pkg::FRS_TX_NINTH], q.txHoldingBuffer},
                                       nBits, parityOn);
        next_q.txLeft = frameLen;
        next_q.txBufferEmptyFlag = 1'b1;
      end
      else
      begin
        next_q.txLeft = 4'h0;
        next_q.txShifter = 13'h1fff;
      end
    end
    // Receiver, synchronous
    if (syncMode)
    begin
      if (fallEv)
      begin
        if (q.rxActive)
        begin
          next_q.rxShifter[q.rxCnt] = rxIn;
          next_q.rxCnt = 4'(q.rxCnt + 4'h1);
        end
        else if (!rxIn)
        begin
          next_q.rxActive = 1'b1;
          next_q.rxShifter = 13'h0000;
          next_q.rxCnt = 4'h1;
          next_q.rxPhase = 4'h0;
        end
      end
      if (riseEv && q.rxActive)
      begin
        next_q.rxPhase = 4'(q.rxPhase + 4'h1);
        if (4'(q.rxPhase + 4'h1) == frameLen)
        begin
          rxDone = 1'b1;
          next_q.rxActive = 1'b0;
        end
      end
    end
    // Receiver, asynchronous: one sample in mid-bit
    else if (divTick)
    begin
      if (!q.rxActive)
      begin
        if (!rxIn)
        begin
          next_q.rxActive = 1'b1;
          next_q.rxPhase = 4'h0;
          next_q.rxCnt = 4'h0;
        end
      end
      else
      begin
        next_q.rxPhase = 4'(q.rxPhase + 4'h1);
        if (q.rxPhase == usa_pkg::ASYNC_MID_BIT)
        begin
          next_q.rxShifter[q.rxCnt] = rxIn;
          next_q.rxCnt = 4'(q.rxCnt + 4'h1);
          if (q.rxCnt == 4'h0 && rxIn)
          begin
            next_q.rxActive = 1'b0;
          end
          else if (4'(q.rxCnt + 4'h1) == frameLen)
          begin
            rxDone = 1'b1;
            next_q.rxActive = 1'b0;
          end
        end
      end
    end
    // Bus write, data phase; a buffer load above used the old contents
    if (ce && q.wrPend)
    begin
      unique case (q.wrAddr)
        usa_pkg::ADDR_TX_HOLDING_BUFFER:
        begin
          next_q.txHoldingBuffer = ahbReq.hwdata[7:0];
          next_q.txBufferEmptyFlag = 1'b0;
        end
        usa_pkg::ADDR_PRESCALE_REG: next_q.prescaleReg = ahbReq.hwdata[7:0];
        usa_pkg::ADDR_BAUD_DIVISOR: next_q.baudDivisor = ahbReq.hwdata[7:0];
        usa_pkg::ADDR_FRAME_SELECT: next_q.frameSel = {1'b0, ahbReq.hwdata[6:0]};
        usa_pkg::ADDR_MODE_SELECT: next_q.modeSel = ahbReq.hwdata[2:0];
        default: next_q.modeSel = next_q.modeSel;
      endcase
    end
    if (rdRxBuf)
    begin
      next_q.rxBufferFullFlag = 1'b0;
    end
    // Completion after the read so a new character is never lost
    if (rxDone)
    begin
      rxWord = (nBits == 4'h7) ? {2'h0, next_q.rxShifter[7:1]} : next_q.rxShifter[9:1];
      rxAccept = !q.modeSel[usa_pkg::MDS_ADDRESS_WAIT] || rxWord[8];
      if (rxAccept)
      begin
        next_q.rxHoldingBuffer = rxWord[7:0];
        next_q.rxBufferFullFlag = 1'b1;
        next_q.rxNinthBit = charLen[1] ? rxWord[8] : 1'b0;
        if (!(ce && q.wrPend && q.wrAddr == usa_pkg::ADDR_MODE_SELECT))
        begin
          next_q.modeSel[usa_pkg::MDS_ADDRESS_WAIT] = 1'b0;
        end
      end
    end
    // Bus address phase
    next_q.wrPend = addrPhase && ahbReq.hwrite;
    next_q.wrAddr = ahbReq.haddr[7:0];
    if (addrPhase && !ahbReq.hwrite)
    begin
      unique case (ahbReq.haddr[7:0])
        usa_pkg::ADDR_RX_HOLDING_BUFFER: next_q.rdData = {24'h0, q.rxHoldingBuffer};
        usa_pkg::ADDR_TX_HOLDING_BUFFER: next_q.rdData = {24'h0, q.txHoldingBuffer};
        usa_pkg::ADDR_PRESCALE_REG: next_q.rdData = {24'h0, q.prescaleReg};
        usa_pkg::ADDR_BAUD_DIVISOR: next_q.rdData = {24'h0, q.baudDivisor};
        usa_pkg::ADDR_FRAME_SELECT: next_q.rdData = {24'h0, q.frameSel};
        usa_pkg::ADDR_MODE_SELECT: next_q.rdData = {29'h0, q.modeSel};
        usa_pkg::ADDR_STATUS: next_q.rdData = {28'h0, q.rxNinthBit, txInProgress,
                                               q.txBufferEmptyFlag, q.rxBufferFullFlag};
        default: next_q.rdData = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.prescaleReg <= usa_pkg::RESET_PSR;
      q.baudDivisor <= usa_pkg::RESET_BAUD;
      q.frameSel <= usa_pkg::RESET_FRS;
      q.modeSel <= usa_pkg::RESET_MDS;
      q.txBufferEmptyFlag <= 1'b1;
      q.txShifter <= 13'h1fff;
      q.inSync1 <= 1'b1;
      q.inSync2 <= 1'b1;
    end
    else if (ce)
    begin
      q <= next_q;
    end
  end

  // Stalling on a low enable keeps the bus in step with frozen state
  assign ahbRsp.hreadyout = ce;
  assign ahbRsp.hresp = 1'b0;
  assign ahbRsp.hrdata = q.rdData;
  assign serialOutPin = q.txShifter[0];
  assign bitClockPinOut = q.clkLvl;
  assign bitClockPinOe = syncMode && !extClock;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_TX_ON_RISE: assert property (@(posedge mclk) disable iff (!resetn)
    ce && syncMode && $changed(q.txShifter[0]) |-> $past(riseEv))
    else $error("Sync transmit changed off a rising edge");
  AST_EMPTY_CLEARED: assert property (@(posedge mclk) disable iff (!resetn)
    ce && q.wrPend && q.wrAddr == usa_pkg::ADDR_TX_HOLDING_BUFFER |=> !q.txBufferEmptyFlag)
    else $error("Transmit empty flag not cleared by write");
  AST_IDLE_LINE: assert property (@(posedge mclk) disable iff (!resetn)
    !txInProgress |-> serialOutPin)
    else $error("Line not idle while transmitter is free");
  AST_LOAD_SETS_EMPTY: assert property (@(posedge mclk) disable iff (!resetn)
    ce && txEv && q.txLeft <= 4'h1 && !q.txBufferEmptyFlag && !q.wrPend
    |=> q.txBufferEmptyFlag && !serialOutPin)
    else $error("Shifter reload did not start a frame");
  AST_RX_LOADS: assert property (@(posedge mclk) disable iff (!resetn)
    ce && rxDone && rxAccept |=> q.rxBufferFullFlag && q.rxHoldingBuffer == $past(rxWord[7:0]))
    else $error("Received character not delivered");
  AST_RX_READ_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
    rdRxBuf && !rxDone |=> !q.rxBufferFullFlag)
    else $error("Read did not clear receive full flag");
  AST_SKIP_DATA: assert property (@(posedge mclk) disable iff (!resetn)
    ce && rxDone && !rxAccept && !rdRxBuf |=> $stable(q.rxHoldingBuffer) && $stable(q.rxBufferFullFlag))
    else $error("Skipped character disturbed the receive buffer");
  AST_ADDRESS_ENDS_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
    ce && rxDone && q.modeSel[usa_pkg::MDS_ADDRESS_WAIT] && rxWord[8] && !q.wrPend
    |=> !q.modeSel[usa_pkg::MDS_ADDRESS_WAIT])
    else $error("Address character did not end the wait");
  AST_STOPPED_CLOCK: assert property (@(posedge mclk) disable iff (!resetn)
    prescale == usa_pkg::PRESCALE_STOPPED |-> !divTick && !riseEv && !fallEv
    ##1 $stable(q.clkLvl) && $stable(q.txShifter))
    else $error("Stopped prescaler still produced ticks");
  AST_DIVIDE_SPACING: assert property (@(posedge mclk) disable iff (!resetn)
    ce && divTick && divisor != 11'h000 && $stable(q.prescaleReg) ##1 ce |-> !divTick)
    else $error("Divisor ticks closer than divisor plus one");
endmodule
`default_nettype wire

// >>> usa_remote_model.sv
/*
  Remote synchronous serial partner of the serial unit: sends frames on
  its own bit clock and captures the unit's frames on falling edges.
  Assumes the bench merges the bit clock pin level and calls its tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module usa_remote_model
(
  input wire logic bitClk,
  input wire logic serOut,
  output logic serIn,
  output logic extClk
);
  int rxBits = 9;
  int cnt = 0;
  logic busy = 1'b0;
  logic [10:0] word = '0;
  logic [10:0] got[$];
  initial
  begin
    serIn = 1'b1;
    extClk = 1'b0;
  end
  // ------------------------------------------------------------------
  // Capture: start bit, data bits, stop bit in word[10]
  // ------------------------------------------------------------------
  always @(negedge bitClk)
  begin
    if (!busy)
    begin
      busy = (serOut === 1'b0);
      cnt = 0;
      word = '0;
    end
    else if (cnt < rxBits)
    begin
      word[cnt] = serOut;
      cnt++;
    end
    else
    begin
      word[10] = serOut;
      got.push_back(word);
      busy = 1'b0;
    end
  end
  // ------------------------------------------------------------------
  // Send: clock rests low between frames; two idle bits close a frame
  // ------------------------------------------------------------------
  task automatic send_frame(input logic [8:0] bits);
    for (int i = 0; i < 13; i++)
    begin
      extClk = 1'b1;
      serIn = (i == 0) ? 1'b0 : (i < 10) ? bits[i-1] : 1'b1;
      #330;
      extClk = 1'b0;
      #330;
    end
  endtask
  // Holding the line is only used to prove the loopback ignores the pin
  task automatic hold_line(input logic v);
    serIn = v;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/*
  Self-checking bench for the serial unit: AHB-Lite register tasks,
  baud, transmit, receive, address-wait and loopback sequences.
  Assumes the remote model file is compiled before this one.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] RX = usa_pkg::ADDR_RX_HOLDING_BUFFER;
  localparam logic [7:0] TX = usa_pkg::ADDR_TX_HOLDING_BUFFER;
  localparam logic [7:0] PSR = usa_pkg::ADDR_PRESCALE_REG;
  localparam logic [7:0] BAUD = usa_pkg::ADDR_BAUD_DIVISOR;
  localparam logic [7:0] FRS = usa_pkg::ADDR_FRAME_SELECT;
  localparam logic [7:0] MODE = usa_pkg::ADDR_MODE_SELECT;
  localparam logic [7:0] ST = usa_pkg::ADDR_STATUS;
  localparam logic [31:0] FULL = 32'h1 << usa_pkg::STA_RX_FULL;
  localparam logic [31:0] EMPTY = 32'h1 << usa_pkg::STA_TX_EMPTY;
  localparam logic [31:0] BUSY = 32'h1 << usa_pkg::STA_TX_IN_PROGRESS;
  localparam logic [31:0] NINTH = 32'h1 << usa_pkg::STA_RX_NINTH;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b1;
  logic ce = 1'b1;
  logic [31:0] hwdata = '0;
  logic [31:0] rdv;
  int errTotal = 0;
  int totalChecks = 0;
  usa_pkg::usa_ahb_req_t ahbReq;
  usa_pkg::usa_ahb_rsp_t ahbRsp;
  wire serialOut, serialIn, extClk, clkOut, clkOe, bitClk;
  always #20 mclk = ~mclk;
  assign ahbReq = {haddr, htrans, hwrite, 3'h2, hsel, ahbRsp.hreadyout, hwdata};
  // Pin level: the unit drives it when enabled, else the remote clock
  assign bitClk = clkOe ? clkOut : extClk;
  usa_serial_unit dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .ahbReq(ahbReq),
    .ahbRsp(ahbRsp), .serialInPin(serialIn), .serialOutPin(serialOut),
    .bitClockPinIn(bitClk), .bitClockPinOut(clkOut), .bitClockPinOe(clkOe));
  usa_remote_model remote_u (.bitClk(bitClk), .serOut(serialOut), .serIn(serialIn),
    .extClk(extClk));
  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  task automatic closeOut;
    if (errTotal == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    errTotal++;
    $display("[FAIL] %s expected done seen timeout", what);
    closeOut();
  endtask
  task automatic waitReady;
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (ahbRsp.hreadyout === 1'b1)
        break;
    end
    if (n == 50)
      hang("hready");
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rdv = ahbRsp.hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, '0);
    chk(rdv & m, e, $sformatf("register %h", a));
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    for (n = 0; n < 600; n++)
    begin
      bus(ST, 1'b0, '0);
      if ((rdv & m) === e)
        break;
    end
    if (n == 600)
      hang("status wait");
  endtask
  // Cycles between two rising edges of the driven bit clock
  task automatic measure(output int p);
    int n;
    int r1;
    logic prev;
    r1 = -1;
    prev = clkOut;
    for (n = 0; n < 6000; n++)
    begin
      @(posedge mclk);
      if (prev === 1'b0 && clkOut === 1'b1)
      begin
        if (r1 >= 0)
          break;
        r1 = n;
      end
      prev = clkOut;
    end
    p = n - r1;
  endtask
  function automatic int nb(logic [7:0] f);
    return (f[1] ? 9 : f[0] ? 7 : 8) + (f[1] ? 0 : int'(f[6]));
  endfunction
  // Even parity sits right after the data bits
  function automatic logic [9:0] fr(logic [7:0] f, logic [7:0] d);
    if (f[1])
      return {1'b0, f[3], d};
    if (f[0])
      return f[6] ? {2'b0, ^d[6:0], d[6:0]} : {3'b0, d[6:0]};
    return f[6] ? {1'b0, ^d, d} : {2'b0, d};
  endfunction
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    int p;
    int n;
    int kk[4] = '{1, 2, 31, 4};
    int dd[4] = '{0, 0, 1, 258};
    logic [7:0] fs[5] = '{8'h0a, 8'h04, 8'h01, 8'h40, 8'h41};
    logic [7:0] ds[5] = '{8'h5c, 8'ha5, 8'hd3, 8'hb0, 8'h07};
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rm(ST, '1, EMPTY);
    rm(PSR, '1, 0);
    rm(FRS, '1, 0);
    rm(MODE, '1, 0);
    wr(8'h1c, 32'hff);
    rm(8'h1c, '1, 0);
    // A transfer without select must leave the registers alone
    hsel <= 1'b0;
    wr(BAUD, 32'h77);
    hsel <= 1'b1;
    rm(BAUD, '1, 0);
    chk(serialOut, 1'b1, "idle line");
    chk(clkOe, 1'b0, "clock pin enable");
    wr(MODE, 32'h1);
    @(posedge mclk);
    chk(clkOe, 1'b1, "clock pin enable");
    for (int i = 0; i < 4; i++)
    begin
      wr(PSR, 0);
      wr(BAUD, {24'h0, dd[i][7:0]});
      wr(PSR, {24'h0, kk[i][4:0], dd[i][10:8]});
      measure(p);
      chk(p, (dd[i] + 1) * (kk[i] + 1), "bit clock period");
    end
    wr(PSR, 0);
    measure(p);
    chk(p, 6001, "stopped clock");
    wr(BAUD, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      wr(FRS, {24'h0, fs[i]});
      remote_u.rxBits = nb(fs[i]);
      remote_u.got.delete();
      wr(PSR, 0);
      wr(TX, {24'h0, ds[i]});
      rm(ST, EMPTY, 0);
      wr(PSR, 32'h08);
      poll(EMPTY, EMPTY);
      wr(TX, {24'h0, ~ds[i]});
      rm(ST, EMPTY | BUSY, BUSY);
      poll(EMPTY, EMPTY);
      rm(ST, BUSY, BUSY);
      poll(BUSY, 0);
      for (n = 0; n < 50 && remote_u.got.size() < 2; n++) @(posedge mclk);
      chk(remote_u.got.size(), 2, "frames sent");
      chk(remote_u.got[0], {1'b1, fr(fs[i], ds[i])}, "frame A");
      chk(remote_u.got[1], {1'b1, fr(fs[i], ~ds[i])}, "frame B");
    end
    wr(MODE, 0);
    wr(FRS, 0);
    wr(PSR, 0);
    wr(BAUD, 32'h1);
    wr(PSR, 32'h08);
    wr(TX, 32'h1);
    for (n = 0; n < 400 && serialOut !== 1'b0; n++) @(posedge mclk);
    for (p = 0; p < 400 && serialOut === 1'b0; p++) @(posedge mclk);
    chk(p, 32, "async bit time");
    poll(BUSY, 0);
    wr(MODE, 32'h3);
    wr(FRS, 32'h2);
    wr(PSR, 32'h08);
    remote_u.send_frame(9'h03c);
    poll(FULL, FULL);
    rm(ST, NINTH, 0);
    rm(RX, '1, 32'h3c);
    rm(ST, FULL, 0);
    wr(MODE, 32'h7);
    remote_u.send_frame(9'h033);
    rm(ST, FULL, 0);
    remote_u.send_frame(9'h1a7);
    poll(FULL, FULL);
    rm(MODE, '1, 32'h3);
    rm(ST, NINTH, NINTH);
    rm(RX, '1, 32'ha7);
    remote_u.send_frame(9'h04e);
    poll(FULL, FULL);
    rm(RX, '1, 32'h4e);
    wr(MODE, 32'h7);
    remote_u.send_frame(9'h011);
    rm(ST, FULL, 0);
    wr(MODE, 32'h1);
    wr(FRS, 32'h0b);
    remote_u.hold_line(1'b0);
    wr(TX, 32'h96);
    poll(FULL, FULL);
    rm(RX, '1, 32'h96);
    rm(ST, NINTH, NINTH);
    // Freeze the unit in mid start bit: line, clock and bus must all hold
    wr(TX, 32'h5a);
    for (n = 0; n < 400 && serialOut !== 1'b0; n++) @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    p = int'(clkOut);
    repeat (20) @(posedge mclk);
    chk(serialOut, 1'b0, "frozen line");
    chk(clkOut, p, "frozen bit clock");
    chk(ahbRsp.hreadyout, 1'b0, "stalled bus");
    ce <= 1'b1;
    poll(FULL, FULL);
    rm(RX, '1, 32'h5a);
    closeOut();
  end
endmodule
`default_nettype wire
